// ==== bht_brake_test.sv ====
// Brake hold test start, sequencing and supervision with its parameter port.
// Assumes feedback and request strobes come from logic on sys_clk_i;
// only the connector inputs are asynchronous.
//
// Contract
// [RL1] Start a test only while the drive is ready to switch on.
// [RL2] A connector input set to request code acts as request when high.
// [RL3] At most one connector input may carry the request code; the code does not check this and ORs all inputs that carry it.
// [RL4] Combined input request shows in its own status variable.
// [RL5] Rising edge of bus request variable starts the test.
// [RL6] Input request and bus request are ORed as start sources.
// [RL7] Telegram request always runs both force directions.
// [RL8] Brake held, force each direction in turn, position watched throughout; the code does not check displacement in the ST_PWR step.
// [RL9] Pass only if displacement never exceeds the allowed limit.
// [RL10] Failed flag on excess movement or missing brake.
// [RL11] State word bit 13 error active, bit 14 acknowledge required.
// [RL12] State word bits 17, 18, 19 mirror elapsed, running, failed.
// [RL13] System state reads 03h normally, 05h while testing.
// [RL14] Error active high while any error is present.
// [RL15] Acknowledge required flag high while acknowledge is needed.
// [RL16] Interval elapsed flag set on expiry, cleared by pass, count restarts.
// [RL17] Running flag high for the whole sequence.
// [RL18] Step code walks 00h through 06h per test phase.
// [RL19] Back in idle the sequence is done and running clears.
// [RL20] A failed test is acknowledged by toggling the acknowledge bit.
// [RL21] Requests while running or not ready are dropped, not queued.
`timescale 1ns/1ps
`include "bht_defines.svh"

module bht_brake_test #(
  parameter int unsigned MS_CYCLES = `BHT_MS_NS / `BHT_CLK_NS
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 srst_i,
  // Parameter access
  input  wire bht_pkg::bht_par_req_t par_req_i,
  output logic [31:0]               par_rdata_o,
  // Request sources
  input  wire logic [3:0]           din_i,
  input  wire logic                 tlg_req_i,
  input  wire logic                 err_ack_i,
  // Drive conditions
  input  wire logic                 ready_i,
  input  wire logic                 brake_cfg_i,
  input  wire bht_pkg::bht_drive_fb_t drive_fb_i,
  // Drive commands
  output logic                      pwr_en_o,
  output logic                      force_pos_o,
  output logic                      force_neg_o,
  output logic                      brake_hold_o,
  // Status
  output logic                      test_running_o,
  output logic                      test_failed_o,
  output logic                      interval_elapsed_o
);

  // ****************************************
  // State
  // ****************************************
  bht_pkg::bht_regs_t q;
  bht_pkg::bht_regs_t d;

  logic        io_req;
  logic [3:0]  in_hit;
  logic        bus_start;
  logic        start;
  logic        running;
  logic [32:0] diff;
  logic [32:0] disp;
  logic        over;
  logic        tick;
  logic [7:0]  step;
  logic [31:0] fn_word;

  // ****************************************
  // Request sources
  // ****************************************
  // Only the second sync flop feeds the decode, never the pin
  for (genvar g = 0; g < 4; g++) begin : g_in_req
    // [RL2] Input as request
    assign in_hit[g] = q.din_s2[g] && (q.func[g] == `BHT_FUNC_REQ_TEST);
  end

  // Several inputs on the code simply merge
  assign io_req = |in_hit;

  // [RL5] Bus request edge
  // [RL7] Telegram edge, both directions
  assign bus_start = (q.bus_req && !q.bus_req_prev) || (tlg_req_i && !q.tlg_prev);
  // [RL6] Sources ORed
  // [RL1] Ready gate
  // [RL21] Dropped while busy
  assign start = ((io_req && !q.io_prev) || bus_start) && ready_i && (q.st == bht_pkg::ST_IDLE);
  // [RL17] Running over whole sequence
  assign running = (q.st != bht_pkg::ST_IDLE);

  // ****************************************
  // Displacement supervision
  // ****************************************
  // Extended by one bit so a full swing cannot wrap
  assign diff = {drive_fb_i.pos[31], drive_fb_i.pos} - {q.pos_start[31], q.pos_start};
  assign disp = diff[32] ? (33'h0_0000_0000 - diff) : diff;
  // [RL9] Limit check
  assign over = running && (q.st != bht_pkg::ST_PWR) && (disp > {1'b0, q.limit});
  assign tick = (q.tick_cnt == 32'(MS_CYCLES - 1));

  // ****************************************
  // Step code and state word
  // ****************************************
  always_comb begin
    // [RL18] Step codes
    case (q.st)
      bht_pkg::ST_PWR:      step = `BHT_STEP_PWR;
      bht_pkg::ST_POS_RAMP: step = `BHT_STEP_POS_RAMP;
      bht_pkg::ST_POS_HOLD: step = `BHT_STEP_POS_HOLD;
      bht_pkg::ST_NEG_RAMP: step = `BHT_STEP_NEG_RAMP;
      bht_pkg::ST_NEG_HOLD: step = `BHT_STEP_NEG_HOLD;
      bht_pkg::ST_RST_CUR:  step = `BHT_STEP_RST_CUR;
      default:              step = `BHT_STEP_IDLE;
    endcase
    fn_word = 32'h0000_0000;
    // [RL11] Error and acknowledge bits
    fn_word[`BHT_BIT_ERR] = q.failed;
    fn_word[`BHT_BIT_ACK] = q.ack_req;
    // [RL12] Test bits
    fn_word[`BHT_BIT_ELAPSED] = q.elapsed;
    fn_word[`BHT_BIT_RUNNING] = running;
    fn_word[`BHT_BIT_FAILED] = q.failed;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d = q;
    d.din_s1 = din_i;
    d.din_s2 = q.din_s1;
    d.io_prev = io_req;
    d.bus_req_prev = q.bus_req;
    d.tlg_prev = tlg_req_i;
    d.ack_prev = err_ack_i;
    d.tick_cnt = tick ? 32'h0000_0000 : q.tick_cnt + 32'h0000_0001;

    // Parameter writes; status variables are read only
    if (par_req_i.wr) begin
      if (par_req_i.addr == `BHT_A_IN5_FUNC) begin
        d.func[0] = par_req_i.wdata[15:0];
      end else if (par_req_i.addr == `BHT_A_IN6_FUNC) begin
        d.func[1] = par_req_i.wdata[15:0];
      end else if (par_req_i.addr == `BHT_A_IN7_FUNC) begin
        d.func[2] = par_req_i.wdata[15:0];
      end else if (par_req_i.addr == `BHT_A_IN8_FUNC) begin
        d.func[3] = par_req_i.wdata[15:0];
      end else if (par_req_i.addr == `BHT_A_BUS_REQ) begin
        d.bus_req = par_req_i.wdata[0];
      end else if (par_req_i.addr == `BHT_A_APPLY_MS) begin
        d.apply_ms = par_req_i.wdata;
      end else if (par_req_i.addr == `BHT_A_DISP_LIMIT) begin
        d.limit = par_req_i.wdata;
      end else if (par_req_i.addr == `BHT_A_INTERVAL) begin
        d.interval = par_req_i.wdata;
      end
    end

    // [RL20] Toggle acknowledges the fault
    if (err_ack_i != q.ack_prev) begin
      d.failed = 1'b0;
      d.ack_req = 1'b0;
    end

    // [RL16] Interval count in ms
    if (tick && !q.elapsed) begin
      if (q.int_cnt + 32'h0000_0001 >= q.interval) begin
        d.elapsed = 1'b1;
      end else begin
        d.int_cnt = q.int_cnt + 32'h0000_0001;
      end
    end

    if (tick && (q.hold_cnt != 32'h0000_0000)) begin
      d.hold_cnt = q.hold_cnt - 32'h0000_0001;
    end

    // [RL8] Brake never released by this block
    d.brake_hold = 1'b1;

    case (q.st)
      bht_pkg::ST_IDLE: begin
        d.pwr_en = 1'b0;
        d.force_pos = 1'b0;
        d.force_neg = 1'b0;
        if (start) begin
          if (!brake_cfg_i) begin
            // [RL10] Missing brake fails at once
            d.failed = 1'b1;
            d.ack_req = 1'b1;
          end else begin
            d.pos_start = drive_fb_i.pos;
            d.pwr_en = 1'b1;
            d.st = bht_pkg::ST_PWR;
          end
        end
      end
      bht_pkg::ST_PWR: begin
        if (drive_fb_i.pwr_ready) begin
          d.force_pos = 1'b1;
          d.st = bht_pkg::ST_POS_RAMP;
        end
      end
      bht_pkg::ST_POS_RAMP: begin
        if (drive_fb_i.cur_reached) begin
          d.hold_cnt = q.apply_ms;
          d.st = bht_pkg::ST_POS_HOLD;
        end
      end
      bht_pkg::ST_POS_HOLD: begin
        // [RL8] Then the other direction
        if (q.hold_cnt == 32'h0000_0000) begin
          d.force_pos = 1'b0;
          d.force_neg = 1'b1;
          d.st = bht_pkg::ST_NEG_RAMP;
        end
      end
      bht_pkg::ST_NEG_RAMP: begin
        if (drive_fb_i.cur_reached) begin
          d.hold_cnt = q.apply_ms;
          d.st = bht_pkg::ST_NEG_HOLD;
        end
      end
      bht_pkg::ST_NEG_HOLD: begin
        if (q.hold_cnt == 32'h0000_0000) begin
          d.force_neg = 1'b0;
          d.st = bht_pkg::ST_RST_CUR;
        end
      end
      bht_pkg::ST_RST_CUR: begin
        d.force_pos = 1'b0;
        d.force_neg = 1'b0;
        if (drive_fb_i.cur_zero) begin
          d.pwr_en = 1'b0;
          // [RL19] Idle ends the sequence
          d.st = bht_pkg::ST_IDLE;
          if (!q.failed) begin
            // [RL16] Pass clears flag, restarts count
            d.elapsed = 1'b0;
            d.int_cnt = 32'h0000_0000;
          end
        end
      end
      default: begin
        d.st = bht_pkg::ST_IDLE;
      end
    endcase

    // [RL9] Excess movement aborts to current reset
    // [RL10] and sets the failed flag
    // [RL14] Error stays until acknowledged
    // [RL15] Acknowledge needed after a fault
    if (over) begin
      d.failed = 1'b1;
      d.ack_req = 1'b1;
      d.force_pos = 1'b0;
      d.force_neg = 1'b0;
      d.st = bht_pkg::ST_RST_CUR;
    end

    // Reads answer one cycle later; unmapped reads give zero
    d.rdata = 32'h0000_0000;
    if (par_req_i.addr == `BHT_A_IN5_FUNC) begin
      d.rdata = {16'h0000, q.func[0]};
    end else if (par_req_i.addr == `BHT_A_IN6_FUNC) begin
      d.rdata = {16'h0000, q.func[1]};
    end else if (par_req_i.addr == `BHT_A_IN7_FUNC) begin
      d.rdata = {16'h0000, q.func[2]};
    end else if (par_req_i.addr == `BHT_A_IN8_FUNC) begin
      d.rdata = {16'h0000, q.func[3]};
    end else if (par_req_i.addr == `BHT_A_SYS_STATE) begin
      // [RL13] Operation or testing
      d.rdata = {24'h00_0000, running ? `BHT_SYS_TESTING : `BHT_SYS_OPERATION};
    end else if (par_req_i.addr == `BHT_A_FN_WORD) begin
      d.rdata = fn_word;
    end else if (par_req_i.addr == `BHT_A_ERR_ACT) begin
      d.rdata = {31'h0000_0000, q.failed};
    end else if (par_req_i.addr == `BHT_A_ACK_REQ) begin
      d.rdata = {31'h0000_0000, q.ack_req};
    end else if (par_req_i.addr == `BHT_A_INT_ELAPSED) begin
      d.rdata = {31'h0000_0000, q.elapsed};
    end else if (par_req_i.addr == `BHT_A_RUNNING) begin
      d.rdata = {31'h0000_0000, running};
    end else if (par_req_i.addr == `BHT_A_FAILED) begin
      d.rdata = {31'h0000_0000, q.failed};
    end else if (par_req_i.addr == `BHT_A_STEP_CODE) begin
      d.rdata = {24'h00_0000, step};
    end else if (par_req_i.addr == `BHT_A_IO_REQ) begin
      // [RL4] Combined input request
      d.rdata = {31'h0000_0000, io_req};
    end else if (par_req_i.addr == `BHT_A_BUS_REQ) begin
      d.rdata = {31'h0000_0000, q.bus_req};
    end else if (par_req_i.addr == `BHT_A_APPLY_MS) begin
      d.rdata = q.apply_ms;
    end else if (par_req_i.addr == `BHT_A_DISP_LIMIT) begin
      d.rdata = q.limit;
    end else if (par_req_i.addr == `BHT_A_INTERVAL) begin
      d.rdata = q.interval;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      q <= '0;
      q.st <= bht_pkg::ST_IDLE;
      q.func <= {4{`BHT_RST_FUNC}};
      q.apply_ms <= `BHT_RST_APPLY_MS;
      q.limit <= `BHT_RST_LIMIT;
      q.interval <= `BHT_RST_INTERVAL;
      // Power up asks for a test straight away
      q.elapsed <= 1'b1;
      q.brake_hold <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign par_rdata_o = q.rdata;
  assign pwr_en_o = q.pwr_en;
  assign force_pos_o = q.force_pos;
  assign force_neg_o = q.force_neg;
  assign brake_hold_o = q.brake_hold;
  assign test_running_o = running;
  assign test_failed_o = q.failed;
  assign interval_elapsed_o = q.elapsed;

endmodule

// ==== bht_defines.svh ====
// Constants for the brake hold test control block.
// Assumes a 125 MHz processing clock and PARAMETER_IDENTIFIER style parameter addresses.
`ifndef BHT_DEFINES_SVH
`define BHT_DEFINES_SVH

// ****************************************
// Timing
// ****************************************
`define BHT_CLK_NS        8
`define BHT_MS_NS         1000000

// ****************************************
// Parameter identifiers
// ****************************************
`define BHT_A_IN5_FUNC    16'h1060
`define BHT_A_IN6_FUNC    16'h1061
`define BHT_A_IN7_FUNC    16'h1062
`define BHT_A_IN8_FUNC    16'h1063
`define BHT_A_SYS_STATE   16'h1a01
`define BHT_A_FN_WORD     16'h1a06
`define BHT_A_ERR_ACT     16'h1a1d
`define BHT_A_ACK_REQ     16'h1a1e
`define BHT_A_INT_ELAPSED 16'h1a21
`define BHT_A_RUNNING     16'h1a22
`define BHT_A_FAILED      16'h1a23
`define BHT_A_STEP_CODE   16'h1a42
`define BHT_A_IO_REQ      16'h1a60
`define BHT_A_BUS_REQ     16'h1a61
`define BHT_A_APPLY_MS    16'h47d8
`define BHT_A_DISP_LIMIT  16'h47d9
`define BHT_A_INTERVAL    16'h47da

// ****************************************
// Fields and codes
// ****************************************
`define BHT_FUNC_REQ_TEST 16'h0007
`define BHT_BIT_ERR       13
`define BHT_BIT_ACK       14
`define BHT_BIT_ELAPSED   17
`define BHT_BIT_RUNNING   18
`define BHT_BIT_FAILED    19
`define BHT_SYS_OPERATION 8'h03
`define BHT_SYS_TESTING   8'h05
`define BHT_STEP_IDLE     8'h00
`define BHT_STEP_PWR      8'h01
`define BHT_STEP_POS_RAMP 8'h02
`define BHT_STEP_POS_HOLD 8'h03
`define BHT_STEP_NEG_RAMP 8'h04
`define BHT_STEP_NEG_HOLD 8'h05
`define BHT_STEP_RST_CUR  8'h06

// ****************************************
// Reset values
// ****************************************
`define BHT_RST_FUNC      16'h0000
`define BHT_RST_APPLY_MS  32'h0000_0064
`define BHT_RST_LIMIT     32'h0000_0100
`define BHT_RST_INTERVAL  32'h0036_ee80

`endif

// ==== bht_pkg.sv ====
// Types for the brake hold test control block.
// Constants live in bht_defines.svh.
package bht_pkg;

  // ****************************************
  // Test sequence states
  // ****************************************
  typedef enum logic [6:0] {
    ST_IDLE     = 7'h01,
    ST_PWR      = 7'h02,
    ST_POS_RAMP = 7'h04,
    ST_POS_HOLD = 7'h08,
    ST_NEG_RAMP = 7'h10,
    ST_NEG_HOLD = 7'h20,
    ST_RST_CUR  = 7'h40
  } bht_state_t;

  // ****************************************
  // Parameter access request
  // ****************************************
  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bht_par_req_t;

  // ****************************************
  // Drive feedback from current loop
  // ****************************************
  typedef struct packed {
    logic        pwr_ready;
    logic        cur_reached;
    logic        cur_zero;
    logic [31:0] pos;
  } bht_drive_fb_t;

  // ****************************************
  // Whole block state
  // ****************************************
  typedef struct packed {
    bht_state_t       st;
    logic [3:0][15:0] func;
    logic [31:0]      apply_ms;
    logic [31:0]      limit;
    logic [31:0]      interval;
    logic             bus_req;
    logic             bus_req_prev;
    logic             tlg_prev;
    logic             io_prev;
    logic             ack_prev;
    logic [3:0]       din_s1;
    logic [3:0]       din_s2;
    logic [31:0]      pos_start;
    logic [31:0]      hold_cnt;
    logic [31:0]      tick_cnt;
    logic [31:0]      int_cnt;
    logic             elapsed;
    logic             failed;
    logic             ack_req;
    logic             pwr_en;
    logic             force_pos;
    logic             force_neg;
    logic             brake_hold;
    logic [31:0]      rdata;
  } bht_regs_t;

endpackage

// ==== bht_props.sv ====
// Checker for the brake hold test block.
// Sees only the block's ports; bound from the bench top file.
`timescale 1ns/1ps
`include "bht_defines.svh"

module bht_props (
  // Clock, reset and inputs
  input  wire logic                  sys_clk_i,
  input  wire logic                  srst_i,
  input  wire bht_pkg::bht_par_req_t par_req_i,
  input  wire logic                  tlg_req_i,
  input  wire logic                  err_ack_i,
  input  wire logic                  ready_i,
  input  wire logic                  brake_cfg_i,
  // Outputs watched
  input  wire logic [31:0]           par_rdata_o,
  input  wire logic                  pwr_en_o,
  input  wire logic                  force_pos_o,
  input  wire logic                  force_neg_o,
  input  wire logic                  brake_hold_o,
  input  wire logic                  test_running_o,
  input  wire logic                  test_failed_o,
  input  wire logic                  interval_elapsed_o
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_tlg_start;
    $rose(tlg_req_i) && ready_i && brake_cfg_i && !test_running_o;
  endsequence
  // Ready low keeps a start out of the same cycle
  sequence s_ack_idle;
    $changed(err_ack_i) && !ready_i && !test_running_o;
  endsequence

  chk_brake_held: assert property (brake_hold_o)
    else $error("brake released");
  chk_force_excl: assert property (!(force_pos_o && force_neg_o))
    else $error("both force directions");
  chk_force_run: assert property ((force_pos_o || force_neg_o) |-> test_running_o)
    else $error("force outside test");
  chk_tlg_start: assert property (s_tlg_start |=> pwr_en_o && test_running_o)
    else $error("telegram start missed");
  chk_no_start: assert property (!ready_i && !test_running_o |=> !test_running_o)
    else $error("start while not ready");
  chk_run_power: assert property (pwr_en_o == test_running_o)
    else $error("running and power differ");
  chk_fail_quiet: assert property ($rose(test_failed_o) |-> !force_pos_o && !force_neg_o)
    else $error("force kept after failure");
  chk_ack_clear: assert property (s_ack_idle |=> !test_failed_o)
    else $error("failure not acknowledged");
  chk_no_brake: assert property ($rose(tlg_req_i) && ready_i && !brake_cfg_i
    && !test_running_o |=> test_failed_o && !test_running_o)
    else $error("missing brake not failed");
  chk_word_bits: assert property (par_req_i.addr == `BHT_A_FN_WORD |=>
    par_rdata_o[19:17] == {$past(test_failed_o), $past(test_running_o),
    $past(interval_elapsed_o)} && par_rdata_o[13] == $past(test_failed_o))
    else $error("state word bits wrong");
  chk_sys_code: assert property (par_req_i.addr == `BHT_A_SYS_STATE |=>
    par_rdata_o == ($past(test_running_o) ? 32'h0000_0005 : 32'h0000_0003))
    else $error("system state code wrong");
endmodule

// ==== bht_drive_model.sv ====
// Current loop stand-in answering power and force commands.
// Same clock as the block; LAT sets how slowly power and current settle.
`timescale 1ns/1ps

module bht_drive_model #(
  parameter int unsigned LAT = 3
) (
  // Clock and commands
  input  wire logic                   sys_clk_i,
  input  wire logic                   pwr_en_i,
  input  wire logic                   force_pos_i,
  input  wire logic                   force_neg_i,
  input  wire logic [31:0]            drift_i,
  // Feedback
  output bht_pkg::bht_drive_fb_t      fb_o
);
  // ****************
  // Settling
  // ****************
  logic [7:0] pe_q = 8'h00;
  logic [7:0] fp_q = 8'h00;
  logic [7:0] fn_q = 8'h00;

  always_ff @(posedge sys_clk_i) begin
    pe_q <= {pe_q[6:0], pwr_en_i};
    fp_q <= {fp_q[6:0], force_pos_i};
    fn_q <= {fn_q[6:0], force_neg_i};
  end

  // Drift only under force, as a slipping brake would show it
  always_comb begin
    fb_o.pwr_ready   = pwr_en_i & pe_q[LAT-1];
    fb_o.cur_reached = (force_pos_i & fp_q[LAT-1]) | (force_neg_i & fn_q[LAT-1]);
    fb_o.cur_zero    = ~(force_pos_i | force_neg_i | fp_q[LAT-1] | fn_q[LAT-1]);
    fb_o.pos         = force_pos_i ? drift_i : (force_neg_i ? -drift_i : 32'h0);
  end
endmodule

// ==== bht_brake_test_bench.sv ====
// Self-checking bench for the brake hold test block.
// Inputs change on the falling edge; a drive model answers the commands.
`timescale 1ns/1ps
`include "bht_defines.svh"

module bht_brake_test_bench;
  logic                   sys_clk_i   = 1'b0;
  logic                   srst_i      = 1'b1;
  bht_pkg::bht_par_req_t  par_req_i   = '0;
  logic [3:0]             din_i       = 4'h0;
  logic                   tlg_req_i   = 1'b0;
  logic                   err_ack_i   = 1'b0;
  logic                   ready_i     = 1'b1;
  logic                   brake_cfg_i = 1'b1;
  logic [31:0]            drift       = 32'h0;
  bht_pkg::bht_drive_fb_t drive_fb_i;
  logic [31:0]            par_rdata_o;
  logic                   pwr_en_o, force_pos_o, force_neg_o, brake_hold_o;
  logic                   test_running_o, test_failed_o, interval_elapsed_o;
  int                     fail_count  = 0;
  int                     checks      = 0;
  int                     cycles      = 0;

  // Short millisecond so hold and interval counts stay brief
  bht_brake_test #(.MS_CYCLES(4)) bht_brake_test_inst (
    .sys_clk_i, .srst_i, .par_req_i, .par_rdata_o, .din_i, .tlg_req_i,
    .err_ack_i, .ready_i, .brake_cfg_i, .drive_fb_i, .pwr_en_o, .force_pos_o,
    .force_neg_o, .brake_hold_o, .test_running_o, .test_failed_o,
    .interval_elapsed_o);

  bht_drive_model #(.LAT(3)) bht_drive_model_inst (
    .sys_clk_i, .pwr_en_i(pwr_en_o), .force_pos_i(force_pos_o),
    .force_neg_i(force_neg_o), .drift_i(drift), .fb_o(drive_fb_i));

  initial forever #4 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  // ****************
  // Tasks
  // ****************
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(negedge sys_clk_i);
    par_req_i = '{wr: 1'b1, addr: a, wdata: d};
    @(negedge sys_clk_i);
    par_req_i.wr = 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] e);
    @(negedge sys_clk_i);
    par_req_i.addr = a;
    @(negedge sys_clk_i);
    cmp(par_rdata_o, e);
  endtask

  task automatic wait_run(input logic v);
    int n = 0;
    while (test_running_o !== v && n < 500) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp({31'h0, test_running_o}, {31'h0, v});
  endtask

  // Read data follows the address every cycle, so one address is watched
  task automatic wait_code(input logic [31:0] e);
    int n = 0;
    while (par_rdata_o !== e && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    cmp(par_rdata_o, e);
  endtask

  task automatic run_steps();
    par_req_i.addr = `BHT_A_STEP_CODE;
    // Let read data from the previous address pass first
    @(negedge sys_clk_i);
    for (int s = 1; s < 7; s++) begin
      wait_code(32'(s));
      if (s == 3) tlg_req_i = 1'b1;
    end
    wait_code(32'h0);
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (16) @(negedge sys_clk_i);
    srst_i = 1'b0;
    wr(`BHT_A_RUNNING, 32'h1);
    rd(`BHT_A_RUNNING, 32'h0);
    rd(`BHT_A_FAILED, 32'h0);
    rd(`BHT_A_SYS_STATE, 32'h3);
    rd(`BHT_A_FN_WORD, 32'h0002_0000);
    rd(16'h0000, 32'h0);
    wr(`BHT_A_APPLY_MS, 32'h2);
    wr(`BHT_A_INTERVAL, 32'h32);
    for (int i = 0; i < 4; i++) begin
      rd(`BHT_A_IN5_FUNC + 16'(i), 32'h0);
      wr(`BHT_A_IN5_FUNC + 16'(i), {16'h0, `BHT_FUNC_REQ_TEST});
      din_i[i] = 1'b1;
      wait_run(1'b1);
      rd(`BHT_A_IO_REQ, 32'h1);
      rd(`BHT_A_SYS_STATE, 32'h5);
      din_i[i] = 1'b0;
      wait_run(1'b0);
      rd(`BHT_A_FAILED, 32'h0);
      wr(`BHT_A_IN5_FUNC + 16'(i), 32'h0);
    end
    drift = 32'h40;
    wr(`BHT_A_BUS_REQ, 32'h1);
    run_steps();
    repeat (6) @(negedge sys_clk_i);
    cmp({31'h0, test_running_o}, 32'h0);
    rd(`BHT_A_INT_ELAPSED, 32'h0);
    repeat (220) @(negedge sys_clk_i);
    rd(`BHT_A_INT_ELAPSED, 32'h1);
    wr(`BHT_A_BUS_REQ, 32'h0);
    ready_i = 1'b0;
    tlg_req_i = 1'b0;
    wr(`BHT_A_BUS_REQ, 32'h1);
    repeat (4) @(negedge sys_clk_i);
    ready_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    cmp({31'h0, test_running_o}, 32'h0);
    // Displacement equal to the limit still passes
    drift = 32'h100;
    tlg_req_i = 1'b1;
    run_steps();
    rd(`BHT_A_FAILED, 32'h0);
    drift = 32'h101;
    wr(`BHT_A_BUS_REQ, 32'h0);
    wr(`BHT_A_BUS_REQ, 32'h1);
    wait_run(1'b1);
    wait_run(1'b0);
    rd(`BHT_A_FN_WORD, 32'h0008_6000);
    rd(`BHT_A_ERR_ACT, 32'h1);
    rd(`BHT_A_ACK_REQ, 32'h1);
    ready_i = 1'b0;
    err_ack_i = 1'b1;
    rd(`BHT_A_FAILED, 32'h0);
    rd(`BHT_A_ERR_ACT, 32'h0);
    ready_i = 1'b1;
    brake_cfg_i = 1'b0;
    tlg_req_i = 1'b0;
    @(negedge sys_clk_i);
    tlg_req_i = 1'b1;
    repeat (4) @(negedge sys_clk_i);
    cmp({31'h0, test_running_o}, 32'h0);
    rd(`BHT_A_FAILED, 32'h1);
    wrap_up();
  end
endmodule

bind bht_brake_test bht_props bht_props_inst (
  .sys_clk_i, .srst_i, .par_req_i, .tlg_req_i, .err_ack_i, .ready_i,
  .brake_cfg_i, .par_rdata_o, .pwr_en_o, .force_pos_o, .force_neg_o,
  .brake_hold_o, .test_running_o, .test_failed_o, .interval_elapsed_o);
